/* logic/dpr_pkg.sv */
`default_nettype none
package dpr_pkg;
  // ---------------------------------------------------------------
  // register addresses on the serial register port
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_MSYNC = 8'h0a; // multichip_sync_cfg
  localparam logic [7:0] ADR_RLIM = 8'h0b; // ramp_limits
  localparam logic [7:0] ADR_RSTEP = 8'h0c; // ramp_step_sizes
  localparam logic [7:0] ADR_RRATE = 8'h0d; // ramp_slope_rates
  localparam logic [7:0] ADR_PROF0 = 8'h0e; // tone_profile_0
  localparam logic [7:0] ADR_PROF7 = 8'h15; // tone_profile_7
  localparam logic [7:0] ADR_RAM = 8'h16; // waveform_ram_port
  localparam int PROF_N = 8; // number of profile registers

  // ---------------------------------------------------------------
  // writable-bit masks, open bits are zero
  // ---------------------------------------------------------------
  localparam logic [31:0] MS_MASK = 32'hfefcf8f8;
  localparam logic [63:0] TONE_MASK = 64'h3fffffffffffffff;
  localparam logic [63:0] RAMP_MASK = 64'h00ffffffc0ffc02f;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] MS_RESET = 32'h00000000;
  localparam logic [63:0] R64_RESET = 64'h0000000000000000;
  localparam logic [31:0] R32_RESET = 32'h00000000;

  // ---------------------------------------------------------------
  // multichip sync field positions
  // ---------------------------------------------------------------
  localparam int MS_VDLY_LSB = 28; // validation delay, 4 bits
  localparam int MS_RXEN_BIT = 27; // receiver enable
  localparam int MS_GENEN_BIT = 26; // generator enable
  localparam int MS_POL_BIT = 25; // generator polarity
  localparam int MS_PRE_LSB = 18; // state preset, 6 bits
  localparam int MS_ODLY_LSB = 11; // generator output delay, 5 bits
  localparam int MS_IDLY_LSB = 3; // receiver input delay, 5 bits

  // ---------------------------------------------------------------
  // profile field positions
  // ---------------------------------------------------------------
  localparam int TP_ASF_LSB = 48; // amplitude scale, 14 bits
  localparam int TP_POW_LSB = 32; // phase offset, 16 bits
  localparam int TP_FTW_LSB = 0; // tuning word, 32 bits
  localparam int RP_RATE_LSB = 40; // address step rate, 16 bits
  localparam int RP_END_LSB = 30; // end address, 10 bits
  localparam int RP_START_LSB = 14; // start address, 10 bits
  localparam int RP_NODWELL_BIT = 5; // no-dwell high
  localparam int RP_ZC_BIT = 3; // zero-crossing enable
  localparam int RP_MODE_LSB = 0; // ram mode, 3 bits
endpackage
`default_nettype wire

/* logic/dpr_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module dpr_sync3 #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out_q
);
  // ---------------------------------------------------------------
  // three-stage synchroniser, value accepted when stages 2 and 3 agree
  // ---------------------------------------------------------------
  logic [W-1:0] s1_q; // metastable stage, read by s2 only
  logic [W-1:0] s2_q; // second stage
  logic [W-1:0] s3_q; // third stage
  wire agree = (s2_q == s3_q); // stable for two samples

  // shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // hold output until the last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out_q <= '0;
    end else if (agree) begin
      sync_out_q <= s3_q;
    end
  end
endmodule // dpr_sync3
`default_nettype wire

/* logic/dpr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module dpr_regs import dpr_pkg::*; #(
  parameter logic [2:0] RAMP_UP_CODE = 3'h1, // ram ramp-up mode code
  parameter logic [2:0] DIRECT_SW_CODE = 3'h0 // ram direct switch code
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire logic [63:0] reg_wdata, // write data, low bits for 32-bit
  output logic [63:0] reg_rdata_q, // read data
  output logic reg_rd_valid_q, // read data valid pulse
  output logic reg_addr_err_q, // unmapped access pulse
  input wire logic io_update, // update strobe
  input wire logic ram_enable, // control_word_one ram enable
  input wire logic ramp_enable, // control_word_two ramp_generator enable
  input wire logic parallel_enable, // control_word_two parallel port
  input wire logic [3:0] internal_profile_ctrl, // internal profile control
  input wire logic [2:0] internal_profile_idx, // profile from ram engine
  input wire logic [2:0] profile_pins, // external profile pins
  input wire logic [31:0] ram_rdata, // ram word at ram_addr_q
  output logic [3:0] sync_valid_delay_q,
  output logic sync_rx_en_q,
  output logic sync_gen_en_q,
  output logic sync_gen_falling_q,
  output logic [5:0] sync_preset_q,
  output logic [4:0] sync_out_delay_q,
  output logic [4:0] sync_in_delay_q,
  output logic ramp_live_q,
  output logic [31:0] ramp_upper_q,
  output logic [31:0] ramp_lower_q,
  output logic [31:0] ramp_dec_step_q,
  output logic [31:0] ramp_inc_step_q,
  output logic [15:0] ramp_neg_rate_q,
  output logic [15:0] ramp_pos_rate_q,
  output logic [2:0] profile_idx_q,
  output logic profile_is_ram_q,
  output logic profile_is_tone_q,
  output logic [13:0] tone_asf_q,
  output logic [15:0] tone_pow_q,
  output logic [31:0] tone_ftw_q,
  output logic [15:0] ram_step_rate_q,
  output logic [9:0] ram_end_q,
  output logic [9:0] ram_start_q,
  output logic [2:0] ram_mode_q,
  output logic ram_no_dwell_q,
  output logic ram_zero_cross_q,
  output logic ram_we_q, // ram word write pulse
  output logic ram_re_q, // ram word read pulse
  output logic [9:0] ram_addr_q, // ram word pointer
  output logic [31:0] ram_wdata_q // ram word data
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // true for any of the eight profile addresses
  function automatic logic is_prof(input logic [7:0] a);
    return (a >= ADR_PROF0) && (a <= ADR_PROF7);
  endfunction

  wire [7:0] prof_off = reg_addr - ADR_PROF0; // profile index offset
  wire [2:0] prof_sel = prof_off[2:0]; // profile index
  wire hit_ms = (reg_addr == ADR_MSYNC);
  wire hit_rlim = (reg_addr == ADR_RLIM);
  wire hit_rstep = (reg_addr == ADR_RSTEP);
  wire hit_rrate = (reg_addr == ADR_RRATE);
  wire hit_prof = is_prof(reg_addr);
  wire hit_ram = (reg_addr == ADR_RAM);
  wire mapped = hit_ms | hit_rlim | hit_rstep | hit_rrate | hit_prof
    | hit_ram;
  wire ram_wr = reg_wr & hit_ram;
  wire ram_rd = reg_rd & hit_ram & ~reg_wr;

  // profile write mask follows the current profile kind
  wire [63:0] prof_mask = ram_enable ? RAMP_MASK : TONE_MASK;

  // ---------------------------------------------------------------
  // buffer registers written by the port, and their active copies
  // ---------------------------------------------------------------
  logic [31:0] ms_buf_q; // multichip_sync_cfg buffer
  logic [63:0] rlim_buf_q; // ramp_limits buffer
  logic [63:0] rstep_buf_q; // ramp_step_sizes buffer
  logic [31:0] rrate_buf_q; // ramp_slope_rates buffer
  logic [63:0] prof_buf_q [PROF_N]; // tone_profile_N buffers
  logic [31:0] ms_act_q; // active multichip sync
  logic [63:0] rlim_act_q; // active ramp limits
  logic [63:0] rstep_act_q; // active ramp steps
  logic [31:0] rrate_act_q; // active ramp rates
  logic [63:0] prof_act_q [PROF_N]; // active profiles

  // next buffer values, open bits forced to zero
  wire [31:0] ms_buf_d = (reg_wr & hit_ms) ?
    (reg_wdata[31:0] & MS_MASK) : ms_buf_q;
  wire [63:0] rlim_buf_d = (reg_wr & hit_rlim) ? reg_wdata : rlim_buf_q;
  wire [63:0] rstep_buf_d = (reg_wr & hit_rstep) ? reg_wdata : rstep_buf_q;
  wire [31:0] rrate_buf_d = (reg_wr & hit_rrate) ?
    reg_wdata[31:0] : rrate_buf_q;

  // scalar buffers only, active copies in the next block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_buf_q <= MS_RESET;
      rlim_buf_q <= R64_RESET;
      rstep_buf_q <= R64_RESET;
      rrate_buf_q <= R32_RESET;
    end else begin
      ms_buf_q <= ms_buf_d;
      rlim_buf_q <= rlim_buf_d;
      rstep_buf_q <= rstep_buf_d;
      rrate_buf_q <= rrate_buf_d;
    end
  end

  // active copies move only on the update strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_act_q <= MS_RESET;
      rlim_act_q <= R64_RESET;
      rstep_act_q <= R64_RESET;
      rrate_act_q <= R32_RESET;
    end else if (io_update) begin
      ms_act_q <= ms_buf_d;
      rlim_act_q <= rlim_buf_d;
      rstep_act_q <= rstep_buf_d;
      rrate_act_q <= rrate_buf_d;
    end
  end

  // one buffer and one active register per profile
  for (genvar g = 0; g < PROF_N; g++) begin : g_prof
    wire wr_this = reg_wr & hit_prof & (prof_sel == 3'(g));
    wire [63:0] buf_d = wr_this ? (reg_wdata & prof_mask) : prof_buf_q[g];
    // profile buffer and active copy
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        prof_buf_q[g] <= R64_RESET;
        prof_act_q[g] <= R64_RESET;
      end else begin
        prof_buf_q[g] <= buf_d;
        if (io_update) begin
          prof_act_q[g] <= buf_d;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [63:0] rd_mux =
    hit_ms ? {32'h0, ms_buf_q} :
    hit_rlim ? rlim_buf_q :
    hit_rstep ? rstep_buf_q :
    hit_rrate ? {32'h0, rrate_buf_q} :
    hit_prof ? prof_buf_q[prof_sel] :
    hit_ram ? {32'h0, ram_rdata} : 64'h0;

  // read data and error answer, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 64'h0;
      reg_rd_valid_q <= 1'b0;
      reg_addr_err_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd & ~reg_wr;
      reg_addr_err_q <= (reg_rd | reg_wr) & ~mapped;
      if (reg_rd & ~reg_wr) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // multichip sync and ramp outputs
  // ---------------------------------------------------------------
  wire [63:0] rgate = {64{ramp_enable}};

  // field extraction from the active copies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_valid_delay_q <= 4'h0;
      sync_rx_en_q <= 1'b0;
      sync_gen_en_q <= 1'b0;
      sync_gen_falling_q <= 1'b0;
      sync_preset_q <= 6'h00;
      sync_out_delay_q <= 5'h00;
      sync_in_delay_q <= 5'h00;
    end else begin
      sync_valid_delay_q <= ms_act_q[MS_VDLY_LSB +: 4];
      sync_rx_en_q <= ms_act_q[MS_RXEN_BIT];
      sync_gen_en_q <= ms_act_q[MS_GENEN_BIT];
      sync_gen_falling_q <= ms_act_q[MS_POL_BIT];
      sync_preset_q <= ms_act_q[MS_PRE_LSB +: 6];
      sync_out_delay_q <= ms_act_q[MS_ODLY_LSB +: 5];
      sync_in_delay_q <= ms_act_q[MS_IDLY_LSB +: 5];
    end
  end

  // ramp values, zero while the ramp_generator is off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_live_q <= 1'b0;
      ramp_upper_q <= 32'h0;
      ramp_lower_q <= 32'h0;
      ramp_dec_step_q <= 32'h0;
      ramp_inc_step_q <= 32'h0;
      ramp_neg_rate_q <= 16'h0;
      ramp_pos_rate_q <= 16'h0;
    end else begin
      ramp_live_q <= ramp_enable;
      ramp_upper_q <= rlim_act_q[63:32] & rgate[31:0];
      ramp_lower_q <= rlim_act_q[31:0] & rgate[31:0];
      ramp_dec_step_q <= rstep_act_q[63:32] & rgate[31:0];
      ramp_inc_step_q <= rstep_act_q[31:0] & rgate[31:0];
      ramp_neg_rate_q <= rrate_act_q[31:16] & rgate[15:0];
      ramp_pos_rate_q <= rrate_act_q[15:0] & rgate[15:0];
    end
  end

  // ---------------------------------------------------------------
  // profile selection
  // ---------------------------------------------------------------
  logic [2:0] pins_sync; // synchronised profile pins
  dpr_sync3 #(.W(3)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(profile_pins),
    .sync_out_q(pins_sync)
  );

  wire auto_sel = ram_enable & (internal_profile_ctrl != 4'h0);
  wire [2:0] idx_d = auto_sel ? internal_profile_idx : pins_sync;
  wire [63:0] pa = prof_act_q[idx_d]; // active profile word
  wire tone_d = ~ram_enable & ~ramp_enable & ~parallel_enable;
  wire [2:0] mode_d = pa[RP_MODE_LSB +: 3];

  // decoded active profile fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      profile_idx_q <= 3'h0;
      profile_is_ram_q <= 1'b0;
      profile_is_tone_q <= 1'b0;
      tone_asf_q <= 14'h0;
      tone_pow_q <= 16'h0;
      tone_ftw_q <= 32'h0;
      ram_step_rate_q <= 16'h0;
      ram_end_q <= 10'h0;
      ram_start_q <= 10'h0;
      ram_mode_q <= 3'h0;
      ram_no_dwell_q <= 1'b0;
      ram_zero_cross_q <= 1'b0;
    end else begin
      profile_idx_q <= idx_d;
      profile_is_ram_q <= ram_enable;
      profile_is_tone_q <= tone_d;
      tone_asf_q <= pa[TP_ASF_LSB +: 14];
      tone_pow_q <= pa[TP_POW_LSB +: 16];
      tone_ftw_q <= pa[TP_FTW_LSB +: 32];
      ram_step_rate_q <= pa[RP_RATE_LSB +: 16];
      ram_end_q <= pa[RP_END_LSB +: 10];
      ram_start_q <= pa[RP_START_LSB +: 10];
      ram_mode_q <= mode_d;
      ram_no_dwell_q <= pa[RP_NODWELL_BIT] & (mode_d == RAMP_UP_CODE);
      ram_zero_cross_q <= pa[RP_ZC_BIT] & (mode_d == DIRECT_SW_CODE);
    end
  end

  // ---------------------------------------------------------------
  // waveform ram word port
  // ---------------------------------------------------------------
  logic reload_q; // pointer must restart at start address
  wire ptr_at_end = (ram_addr_q == ram_end_q);
  wire [9:0] ptr_inc = ram_addr_q + 10'h001;
  // start address of the newly active profile, not the stale registered copy
  wire [9:0] start_d = pa[RP_START_LSB +: 10];

  // reload after update or a profile change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= 1'b1;
    end else begin
      reload_q <= io_update | (idx_d != profile_idx_q);
    end
  end

  // word pointer walks start to end, then wraps to start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_addr_q <= 10'h0;
    end else if (ram_wr | ram_rd) begin
      ram_addr_q <= ptr_at_end ? ram_start_q : ptr_inc;
    end else if (reload_q) begin
      ram_addr_q <= start_d;
    end
  end

  // ram strobes and write data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_we_q <= 1'b0;
      ram_re_q <= 1'b0;
      ram_wdata_q <= 32'h0;
    end else begin
      ram_we_q <= ram_wr;
      ram_re_q <= ram_rd;
      if (ram_wr) begin
        ram_wdata_q <= reg_wdata[31:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_ms_write;
    reg_wr && hit_ms;
  endsequence

  sequence s_update_done;
    io_update ##2 1'b1;
  endsequence

  a_open_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_ms_write |=> (ms_buf_q & ~MS_MASK) == 32'h0)
    else $error("open sync bits were stored");

  a_update_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !io_update && reg_wr && hit_ms |=> ms_act_q == $past(ms_act_q))
    else $error("sync register moved without update");

  a_sync_fields_out: assert property (@(posedge clk) disable iff (!rst_n)
    s_update_done |-> sync_rx_en_q == ms_buf_q[MS_RXEN_BIT]
      && sync_preset_q == ms_buf_q[MS_PRE_LSB +: 6]
      || $past(reg_wr))
    else $error("sync fields not presented after update");

  a_ramp_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !ramp_enable |=> ramp_upper_q == 32'h0 && ramp_pos_rate_q == 16'h0
      && !ramp_live_q)
    else $error("ramp value visible while ramp off");

  a_ramp_upper: assert property (@(posedge clk) disable iff (!rst_n)
    ramp_enable |=> ramp_upper_q == $past(rlim_act_q[63:32]))
    else $error("ramp upper limit wrong half");

  a_pin_select: assert property (@(posedge clk) disable iff (!rst_n)
    !auto_sel |=> profile_idx_q == $past(pins_sync))
    else $error("profile not taken from pins");

  a_auto_select: assert property (@(posedge clk) disable iff (!rst_n)
    auto_sel |=> profile_idx_q == $past(internal_profile_idx))
    else $error("internal profile control ignored");

  a_tone_mode: assert property (@(posedge clk) disable iff (!rst_n)
    profile_is_tone_q |-> !profile_is_ram_q)
    else $error("profile both tone and ram");

  a_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    ram_wr && ptr_at_end |=> ram_addr_q == $past(ram_start_q))
    else $error("ram pointer failed to wrap");

  a_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && !reg_wr && !mapped |=> reg_rd_valid_q && reg_addr_err_q
      && reg_rdata_q == 64'h0)
    else $error("unmapped read not answered");

  a_zero_cross: assert property (@(posedge clk) disable iff (!rst_n)
    ram_zero_cross_q |-> ram_mode_q == DIRECT_SW_CODE)
    else $error("zero crossing outside direct switch");
endmodule // dpr_regs
`default_nettype wire

/* testbench/dpr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dpr_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [63:0] reg_wdata,
  output logic io_update,
  output logic [2:0] profile_pins,
  input wire logic ram_we_q,
  input wire logic [9:0] ram_addr_q,
  input wire logic [31:0] ram_wdata_q,
  output logic [31:0] ram_rdata
);
  logic [31:0] mem [1024]; // waveform store behind the ram port
  logic [9:0] last_addr_q; // pointer value of the request cycle
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 64'h0;
    io_update = 1'b0;
    profile_pins = 3'h0;
  end
  assign ram_rdata = mem[ram_addr_q];
  // store a word at the pointer seen when the write was taken
  always @(posedge clk) begin
    last_addr_q <= ram_addr_q;
    if (ram_we_q) begin
      mem[last_addr_q] <= ram_wdata_q;
    end
  end
  // one-cycle write strobe with address and data held
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // update strobe, then let the active copies settle
  task automatic upd();
    @(posedge clk);
    io_update <= 1'b1;
    @(posedge clk);
    io_update <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // choose the profile on the select pins
  task automatic pins(input logic [2:0] p);
    @(posedge clk);
    profile_pins <= p;
    repeat (8) @(posedge clk);
  endtask
endmodule // dpr_host
`default_nettype wire

/* testbench/dpr_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module dpr_regs_test import dpr_pkg::*;;
  logic clk, rst_n, reg_wr, reg_rd, io_update, ram_enable, ramp_enable;
  logic parallel_enable, reg_rd_valid_q, reg_addr_err_q, sync_rx_en_q;
  logic sync_gen_en_q, sync_gen_falling_q, ramp_live_q, profile_is_ram_q;
  logic profile_is_tone_q, ram_no_dwell_q, ram_zero_cross_q, ram_we_q, ram_re_q;
  logic [2:0] internal_profile_idx, profile_pins, profile_idx_q, ram_mode_q;
  logic [3:0] internal_profile_ctrl, sync_valid_delay_q;
  logic [4:0] sync_out_delay_q, sync_in_delay_q;
  logic [5:0] sync_preset_q;
  logic [7:0] reg_addr;
  logic [9:0] ram_end_q, ram_start_q, ram_addr_q, a;
  logic [13:0] tone_asf_q;
  logic [15:0] ramp_neg_rate_q, ramp_pos_rate_q, tone_pow_q, ram_step_rate_q;
  logic [31:0] ramp_upper_q, ramp_lower_q, ramp_dec_step_q, ramp_inc_step_q;
  logic [31:0] tone_ftw_q, ram_rdata, ram_wdata_q, w [4];
  logic [63:0] reg_wdata, reg_rdata_q, d, s, r, p [8];
  int num_errors = 0;
  int n_checks = 0;
  dpr_regs dut (.*);
  dpr_host h (.*);
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // read one register and compare the answer
  task automatic chkrd(input logic [7:0] ad, input logic [63:0] e);
    h.rd(ad);
    #1;
    `CHK(reg_rd_valid_q, 1'b1)
    `CHK(reg_rdata_q, e)
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'hd9ef));
    {rst_n, ram_enable, ramp_enable, parallel_enable} = 4'h0;
    {internal_profile_ctrl, internal_profile_idx} = 7'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // ---------------------------------------------------------------
    // sync register: reset, masking, buffering, field placement
    // ---------------------------------------------------------------
    chkrd(ADR_MSYNC, 64'h0);
    s = 64'h0;
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 64'hffffffff : {32'h0, $urandom};
      h.wr(ADR_MSYNC, d);
      chkrd(ADR_MSYNC, d & {32'h0, MS_MASK});
      `CHK(sync_preset_q, s[23:18])
      h.upd();
      `CHK(sync_valid_delay_q, d[31:28])
      `CHK({sync_rx_en_q, sync_gen_en_q}, d[27:26])
      `CHK(sync_gen_falling_q, d[25])
      `CHK(sync_preset_q, d[23:18])
      `CHK(sync_out_delay_q, d[15:11])
      `CHK(sync_in_delay_q, d[7:3])
      s = d;
    end
    $display("sync test done");
    // ---------------------------------------------------------------
    // ramp registers, live only with the ramp enabled
    // ---------------------------------------------------------------
    d = {$urandom, $urandom};
    p[0] = {$urandom, $urandom};
    r = {32'h0, $urandom};
    h.wr(ADR_RLIM, d);
    h.wr(ADR_RSTEP, p[0]);
    h.wr(ADR_RRATE, r);
    h.upd();
    `CHK({ramp_upper_q, ramp_inc_step_q, ramp_pos_rate_q}, 80'h0)
    @(posedge clk);
    ramp_enable <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(ramp_live_q, 1'b1)
    `CHK({ramp_upper_q, ramp_lower_q}, d)
    `CHK({ramp_dec_step_q, ramp_inc_step_q}, p[0])
    `CHK({ramp_neg_rate_q, ramp_pos_rate_q}, r[31:0])
    `CHK(profile_is_tone_q, 1'b0)
    @(posedge clk);
    ramp_enable <= 1'b0;
    $display("ramp test done");
    // ---------------------------------------------------------------
    // tone profiles chosen by the select pins
    // ---------------------------------------------------------------
    for (int i = 0; i < PROF_N; i++) begin
      p[i] = (i == 7) ? 64'hffffffffffffffff : {$urandom, $urandom};
      h.wr(ADR_PROF0 + 8'(i), p[i]);
      chkrd(ADR_PROF0 + 8'(i), p[i] & TONE_MASK);
    end
    h.upd();
    for (int i = PROF_N - 1; i >= 0; i--) begin
      h.pins(3'(i));
      #1;
      `CHK(profile_idx_q, 3'(i))
      `CHK(profile_is_tone_q, 1'b1)
      `CHK({tone_asf_q, tone_pow_q, tone_ftw_q}, p[i][61:0])
    end
    $display("tone test done");
    // ---------------------------------------------------------------
    // ram profiles, every mode code, internal profile control
    // ---------------------------------------------------------------
    @(posedge clk);
    ram_enable <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      r = {$urandom, $urandom} | 64'h28;
      r[2:0] = 3'(m);
      h.wr(ADR_PROF0, r);
      chkrd(ADR_PROF0, r & RAMP_MASK);
      h.upd();
      `CHK(profile_is_ram_q, 1'b1)
      `CHK(ram_step_rate_q, r[55:40])
      `CHK({ram_end_q, ram_start_q}, {r[39:30], r[23:14]})
      `CHK(ram_mode_q, 3'(m))
      `CHK(ram_no_dwell_q, m == 1)
      `CHK(ram_zero_cross_q, m == 0)
    end
    @(posedge clk);
    internal_profile_ctrl <= 4'h3;
    internal_profile_idx <= 3'h5;
    repeat (3) @(posedge clk);
    #1;
    `CHK(profile_idx_q, 3'h5)
    @(posedge clk);
    internal_profile_ctrl <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK(profile_idx_q, 3'h0)
    $display("ram profile test done");
    // ---------------------------------------------------------------
    // ram port across the top of the address space, unmapped access
    // ---------------------------------------------------------------
    h.wr(ADR_PROF0, {24'h0, 10'd1, 6'h0, 10'd1022, 14'h1});
    h.upd();
    a = 10'd1022;
    `CHK(ram_addr_q, a)
    for (int k = 0; k < 4; k++) begin
      w[k] = $urandom;
      h.wr(ADR_RAM, {32'h0, w[k]});
      #1;
      a = (a == 10'd1) ? 10'd1022 : a + 10'd1;
      `CHK({ram_we_q, ram_wdata_q, ram_addr_q}, {1'b1, w[k], a})
    end
    for (int k = 0; k < 4; k++) begin
      chkrd(ADR_RAM, {32'h0, w[k]});
      `CHK(ram_re_q, 1'b1)
    end
    h.rd(8'h17);
    #1;
    `CHK({reg_addr_err_q, reg_rd_valid_q, reg_rdata_q}, {2'b11, 64'h0})
    h.wr(8'h09, 64'hffffffff);
    #1;
    `CHK(reg_addr_err_q, 1'b1)
    chkrd(ADR_MSYNC, s & {32'h0, MS_MASK});
    $display("ram port test done");
    test_done();
  end
endmodule // dpr_regs_test
`default_nettype wire
